// >>> core_intc_model.sv
module core_intc_model (
	input  wire        clock,
	input  wire        sleeping,
	input  wire [31:0] enabled,
	output reg  [31:0] wake_mask
);
	timeunit 1ns;
	timeprecision 1ns;
	// Frozen while asleep so the catcher sees the mask of the entry moment
	always @(posedge clock) begin
		if (!sleeping)
			wake_mask <= #1 enabled;
	end
endmodule

// >>> reset_wake_power_sequencer.v
`include "seq_defs.vh"

// Behaviour
// - Deep power-down entered only on the real-time clock request.
// - In deep power-down, power kept only for RTC and reset pin.
// - Leave deep power-down on reset pin or RTC alarm.
// - Catcher wakes CPU on any masked line, without polling.
// - Each peripheral has its own software-controlled gate.
// - Chip reset merges pin, watchdog, power-on and brown-out stage two.
// - Any reset drives indicator low and starts the wake-up timer.
// - Internal reset holds until pin released, oscillator, count, flash ready.
// - Indicator returns high at reset release or supply recovery.
// - After reset, fetch begins at address zero.
// - Supply below 2.2 V raises brown-out interrupt line.
// - Brown-out stage one is an interrupt or a pollable status bit.
// - Supply below 1.85 V asserts chip reset.
// - Brown-out reset holds down to 1 V, then power-on reset.
// - Both brown-out thresholds use hysteresis.
// - Level external interrupt may wake from power-down when enabled.
// - Wake resumes after 4 RC or 4096 oscillator cycles.
module reset_wake_power_sequencer (
	input  wire                 clock,
	input  wire                 rst_b,
	input  wire                 ext_reset_pin_b,
	input  wire                 watchdog_timeout,
	input  wire                 power_on_reset,
	input  wire                 bod_low_set,
	input  wire                 bod_low_clear,
	input  wire                 bod_crit_set,
	input  wire                 bod_crit_clear,
	input  wire                 osc_running,
	input  wire                 flash_init_done,
	input  wire                 main_osc_selected,
	input  wire                 rtc_dpd_request,
	input  wire                 rtc_alarm,
	input  wire                 cpu_sleep_request,
	input  wire                 cpu_powerdown,
	input  wire [`IRQ_W-1:0]    core_irq_mask,
	input  wire [`IRQ_W-1:0]    irq_lines,
	input  wire                 ext_level_irq,
	input  wire                 ext_irq_wake_enable,
	input  wire [`PERIPH_W-1:0] periph_enable,
	output reg                  reset_output_indicator,
	output reg                  chip_reset_b,
	output reg  [31:0]          boot_fetch_addr,
	output reg                  bod_irq,
	output reg                  bod_status,
	output reg                  main_domain_power,
	output reg                  cpu_wake,
	output reg                  cpu_clock_run,
	output reg  [`PERIPH_W-1:0] periph_gate
);
	localparam S_RESET = 5'b00001;
	localparam S_RUN   = 5'b00010;
	localparam S_SLEEP = 5'b00100;
	localparam S_DPD   = 5'b01000;
	localparam S_WAKE  = 5'b10000;

	wire [7:0] raw = {ext_reset_pin_b, watchdog_timeout, power_on_reset,
		rtc_dpd_request, rtc_alarm, ext_level_irq, osc_running,
		flash_init_done};
	wire [7:0] syn;
	wire [`IRQ_W-1:0] irq_s;

	sync2 #(.W(8)) u_sync_ctl (
		.clock     (clock),
		.rst_b     (rst_b),
		.async_in  (raw),
		.reset_val (8'h00),
		.sync_out  (syn)
	);
	sync2 #(.W(`IRQ_W)) u_sync_irq (
		.clock     (clock),
		.rst_b     (rst_b),
		.async_in  (irq_lines),
		.reset_val ({`IRQ_W{1'b0}}),
		.sync_out  (irq_s)
	);

	wire pin_b     = syn[7];
	wire wdt       = syn[6];
	wire por       = syn[5];
	wire dpd_req   = syn[4];
	wire alarm     = syn[3];
	wire ext_lvl   = syn[2];
	wire osc_ok    = syn[1];
	wire flash_ok  = syn[0];

	reg [4:0]        state;
	reg [4:0]        next_state;
	reg [`CNT_W-1:0] count;
	reg [`IRQ_W-1:0] wake_mask;
	reg              ext_wake_en;
	reg              bod_reset;
	reg              was_bod;

	// Shared decode of the reset state, applied only to the next state at each use
	function in_reset;
		input [4:0] s;
		begin
			in_reset = (s == S_RESET);
		end
	endfunction

	// Comparators carry hysteresis: separate set and clear levels
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bod_reset <= 1'b0;
			bod_irq   <= 1'b0;
		end else begin
			if (bod_crit_set)
				bod_reset <= 1'b1;
			else if (bod_crit_clear)
				bod_reset <= 1'b0;
			if (bod_low_set)
				bod_irq <= 1'b1;
			else if (bod_low_clear)
				bod_irq <= 1'b0;
		end
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			bod_status <= 1'b0;
		else
			bod_status <= bod_irq;
	end

	// Power-on reset covers supply below where brown-out stops holding
	wire any_reset = !pin_b || wdt || por || bod_reset;

	wire irq_hit  = |(irq_s & wake_mask);
	wire ext_hit  = ext_wake_en && ext_lvl;
	wire dpd_exit = !pin_b || alarm;
	wire [`CNT_W-1:0] wake_cycles = main_osc_selected ?
		`WAKE_OSC_CYC : `WAKE_IRC_CYC;

	always @* begin
		next_state = state;
		case (state)
		S_RESET: begin
			// At least, not exactly: a late flash must not strand the count
			if (!any_reset && osc_ok && flash_ok &&
				count >= `RST_HOLD_CYC)
				next_state = S_RUN;
		end
		S_RUN: begin
			if (dpd_req)
				next_state = S_DPD;
			else if (cpu_sleep_request)
				next_state = S_SLEEP;
		end
		S_SLEEP: begin
			if (irq_hit || (cpu_powerdown && ext_hit))
				next_state = S_WAKE;
		end
		S_DPD: begin
			if (dpd_exit)
				next_state = S_RESET;
		end
		S_WAKE: begin
			if (count == wake_cycles)
				next_state = S_RUN;
		end
		default: next_state = S_RESET;
		endcase
		if (any_reset && state != S_DPD)
			next_state = S_RESET;
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state       <= S_RESET;
			count       <= {`CNT_W{1'b0}};
			wake_mask   <= {`IRQ_W{1'b0}};
			ext_wake_en <= 1'b0;
			was_bod     <= 1'b0;
		end else begin
			state <= next_state;
			if (next_state != state || any_reset)
				count <= {`CNT_W{1'b0}};
			else if (count != {`CNT_W{1'b1}})
				count <= count + 1'b1;
			if (state == S_RUN && next_state == S_SLEEP) begin
				wake_mask   <= core_irq_mask;
				ext_wake_en <= ext_irq_wake_enable;
			end
			if (bod_reset)
				was_bod <= 1'b1;
			else if (state == S_RUN)
				was_bod <= 1'b0;
		end
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reset_output_indicator <= 1'b0;
			chip_reset_b           <= 1'b0;
			boot_fetch_addr        <= `RESET_VECTOR;
			main_domain_power      <= 1'b1;
			cpu_wake               <= 1'b0;
			cpu_clock_run          <= 1'b0;
			periph_gate            <= `PERIPH_RST;
		end else begin
			chip_reset_b <= !in_reset(next_state);
			// Brown-out reset frees the pin as soon as supply recovers
			if (any_reset)
				reset_output_indicator <= 1'b0;
			else if (!in_reset(next_state) || was_bod)
				reset_output_indicator <= 1'b1;
			if (in_reset(next_state))
				boot_fetch_addr <= `RESET_VECTOR;
			main_domain_power <= (next_state != S_DPD);
			cpu_wake      <= (state == S_SLEEP && next_state == S_WAKE);
			cpu_clock_run <= (next_state == S_RUN);
			if (in_reset(next_state))
				periph_gate <= `PERIPH_RST;
			else
				periph_gate <= periph_enable;
		end
	end
endmodule

// >>> reset_wake_power_sequencer_properties.sv
module seq_props (
	input wire        clock,
	input wire        rst_b,
	input wire        ext_reset_pin_b,
	input wire        watchdog_timeout,
	input wire        bod_low_set,
	input wire        bod_crit_set,
	input wire        flash_init_done,
	input wire        main_osc_selected,
	input wire        reset_output_indicator,
	input wire        chip_reset_b,
	input wire [31:0] boot_fetch_addr,
	input wire        bod_irq,
	input wire        bod_status,
	input wire        cpu_wake,
	input wire        cpu_clock_run
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	AST_BOOT_ZERO: assert property (boot_fetch_addr == 32'h0)
		else $error("boot address not zero");
	AST_WDOG_IND: assert property (watchdog_timeout[*4] |-> !reset_output_indicator)
		else $error("indicator high in watchdog reset");
	AST_FLASH_HOLD: assert property (!flash_init_done[*4] |-> !chip_reset_b)
		else $error("reset released before flash ready");
	AST_PIN_HOLD: assert property (!ext_reset_pin_b[*4] |-> !chip_reset_b)
		else $error("reset released with pin low");
	AST_CRIT_RST: assert property (bod_crit_set[*3] |-> !chip_reset_b)
		else $error("no reset on critical supply");
	AST_LOW_IRQ: assert property (bod_low_set[*2] |-> bod_irq)
		else $error("no brown-out interrupt");
	AST_STATUS: assert property ($rose(bod_irq) |=> bod_status)
		else $error("status bit missing");
	AST_IRC_RESUME: assert property (cpu_wake && !main_osc_selected |-> ##[2:8] cpu_clock_run)
		else $error("late resume after wake");
	cover property (cpu_wake);
	cover property ($rose(chip_reset_b));
	cover property (bod_crit_set && !chip_reset_b);
endmodule
bind reset_wake_power_sequencer seq_props i_props (.*);

// >>> seq_defs.vh
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH
`define IRQ_W         32
`define PERIPH_W      32
`define RESET_VECTOR  32'h0000_0000
`define CLK_MHZ       25
`define CNT_W         13
`define WAKE_IRC_CYC  13'h0004
`define WAKE_OSC_CYC  13'h1000
`define RST_HOLD_CYC  13'h1000
`define PERIPH_RST    32'h0000_0000
`endif

// >>> sync2.v
module sync2 #(
	parameter W = 1
) (
	input  wire         clock,
	input  wire         rst_b,
	input  wire [W-1:0] async_in,
	input  wire [W-1:0] reset_val,
	output reg  [W-1:0] sync_out
);
	// First stage is read only by the second
	reg [W-1:0] meta;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta     <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// >>> tb_reset_wake_power_sequencer.sv
module tb_reset_wake_power_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst_b = 0, ext_reset_pin_b = 0, watchdog_timeout = 0;
	logic power_on_reset = 0, bod_low_set = 0, bod_low_clear = 1;
	logic bod_crit_set = 0, bod_crit_clear = 1, osc_running = 0;
	logic flash_init_done = 0, main_osc_selected = 0, rtc_dpd_request = 0;
	logic rtc_alarm = 0, cpu_sleep_request = 0, cpu_powerdown = 0;
	logic ext_level_irq = 0, ext_irq_wake_enable = 0;
	logic [31:0] irq_lines = 0, periph_enable = 0, irq_enabled = 0;
	wire [31:0] core_irq_mask, boot_fetch_addr, periph_gate;
	wire reset_output_indicator, chip_reset_b, bod_irq, bod_status;
	wire main_domain_power, cpu_wake, cpu_clock_run;
	int err_count = 0, samples_checked = 0, n;
	always #20 clock = ~clock;
	reset_wake_power_sequencer i_dut (.*);
	core_intc_model i_intc (.clock(clock), .sleeping(cpu_sleep_request),
		.enabled(irq_enabled), .wake_mask(core_irq_mask));
	task chk(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task tick(int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task results();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wait_rel(int pre);
		n = 0;
		while (chip_reset_b !== 1'h1 && n < 5000) begin
			tick(1);
			n++;
		end
		chk(n + pre >= 4096 && n + pre < 4110, 1'h1);
		chk(reset_output_indicator, 1'h1);
	endtask
	task t_power_up();
		tick(3);
		chk(reset_output_indicator, 1'h0);
		ext_reset_pin_b = 1;
		osc_running = 1;
		tick(20);
		chk(chip_reset_b, 1'h0);
		flash_init_done = 1;
		wait_rel(20);
		chk(boot_fetch_addr, 32'h0);
		periph_enable = 32'h0000_00a5;
		tick(4);
		chk(periph_gate, 32'h0000_00a5);
		$display("power-up done");
	endtask
	task t_wake();
		irq_enabled = 32'h0000_0004;
		tick(1);
		cpu_sleep_request = 1;
		tick(3);
		irq_enabled = 0;
		irq_lines = 32'h0000_0001;
		tick(6);
		chk(cpu_clock_run, 1'h0);
		irq_lines = 32'h0000_0005;
		n = 0;
		while (cpu_wake !== 1'h1 && n < 10) begin
			tick(1);
			n++;
		end
		chk(cpu_wake, 1'h1);
		cpu_sleep_request = 0;
		irq_lines = 0;
		tick(8);
		chk(cpu_clock_run, 1'h1);
		$display("wake done");
	endtask
	task t_ext();
		ext_irq_wake_enable = 1;
		cpu_powerdown = 1;
		cpu_sleep_request = 1;
		tick(4);
		chk(cpu_clock_run, 1'h0);
		ext_level_irq = 1;
		n = 0;
		while (cpu_wake !== 1'h1 && n < 10) begin
			tick(1);
			n++;
		end
		chk(cpu_wake, 1'h1);
		cpu_sleep_request = 0;
		cpu_powerdown = 0;
		ext_level_irq = 0;
		ext_irq_wake_enable = 0;
		tick(8);
		chk(cpu_clock_run, 1'h1);
		$display("external wake done");
	endtask
	task t_dpd();
		rtc_dpd_request = 1;
		tick(4);
		chk(main_domain_power, 1'h0);
		chk(chip_reset_b, 1'h1);
		rtc_dpd_request = 0;
		rtc_alarm = 1;
		tick(4);
		chk(main_domain_power, 1'h1);
		chk(chip_reset_b, 1'h0);
		rtc_alarm = 0;
		wait_rel(0);
		$display("deep power-down done");
	endtask
	task t_wdog();
		watchdog_timeout = 1;
		tick(4);
		chk(chip_reset_b, 1'h0);
		chk(periph_gate, 32'h0000_0000);
		watchdog_timeout = 0;
		wait_rel(0);
		$display("watchdog done");
	endtask
	task t_bod();
		bod_low_clear = 0;
		bod_low_set = 1;
		tick(3);
		chk(bod_status, 1'h1);
		bod_crit_clear = 0;
		bod_crit_set = 1;
		tick(2);
		chk(chip_reset_b, 1'h0);
		bod_crit_set = 0;
		bod_low_set = 0;
		tick(4);
		chk(bod_irq, 1'h1);
		chk(reset_output_indicator, 1'h0);
		bod_crit_clear = 1;
		bod_low_clear = 1;
		wait_rel(0);
		$display("brown-out done");
	endtask
	initial begin
		#(40 * 30000);
		err_count++;
		results();
	end
	initial begin
		tick(10);
		rst_b = 1;
		t_power_up();
		t_wake();
		t_ext();
		t_dpd();
		t_wdog();
		t_bod();
		results();
	end
endmodule
